// ---- hdl/data_pointer_reg.sv ----
// One 16-bit data pointer with wrapping increment and decrement.
`timescale 1ns/10ps
module data_pointer_reg #(
	parameter int PTR_W = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Step control
	input  wire logic             stepEn,
	input  wire logic             stepDown,
	// Pointer value
	output logic      [PTR_W-1:0] pointer_q
);

	logic [PTR_W-1:0] pointer_d;

	// ----------------------------------------------------------------
	// Next value
	// ----------------------------------------------------------------
	// The sum is cut to the pointer width so that it wraps modulo 2^16.
	always_comb begin
		pointer_d = pointer_q;
		if (stepEn) begin
			if (stepDown) begin
				pointer_d = PTR_W'(pointer_q - move_ops_pkg::PTR_ONE);
			end else begin
				pointer_d = PTR_W'(pointer_q + move_ops_pkg::PTR_ONE);
			end
		end
	end

	// Register.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pointer_q <= move_ops_pkg::PTR_RESET;
		end else begin
			pointer_q <= pointer_d;
		end
	end

endmodule // data_pointer_reg

// ---- hdl/literal_and_indirect_moves.sv ----
// Execution of the literal and indirect move instruction group.
//
// Overview of operation
// - Indirect move transfers a byte between working register and pointed location.
// - Mode 00 pre-increment, 01 pre-decrement, 10 post-increment, 11 post-decrement.
// - Indirect windows hold no data; accesses go to the pointer's address.
// - Pointers are 16 bits and wrap around modulo the full range.
// - Load-bank copies its 5-bit immediate into the bank select register.
// - Load-latch copies its 7-bit immediate into the program-counter high latch.
// - Load-literal puts its 8-bit immediate into the working register.
// - Store copies working register to the addressed file register, keeping it.
// - Offset form addresses pointer plus signed offset, pointer left unchanged.
`timescale 1ns/10ps
module literal_and_indirect_moves (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Decoded instruction
	input  wire logic        opValid,
	input  wire logic [3:0]  opCode,
	input  wire logic        ptrSel,
	input  wire logic [1:0]  pointerUpdateMode,
	input  wire logic [5:0]  offset,
	input  wire logic [7:0]  literal,
	input  wire logic [6:0]  fileAddr,
	// Data memory read return
	input  wire logic        memRdValid,
	input  wire logic [7:0]  memRdata,
	// Data memory request
	output logic             memReq_q,
	output logic             memWe_q,
	output logic      [15:0] memAddr_q,
	output logic      [7:0]  memWdata_q,
	// File register write
	output logic             fileWe_q,
	output logic      [6:0]  fileWaddr_q,
	output logic      [7:0]  fileWdata_q,
	// Core state
	output logic      [7:0]  workingReg_q,
	output logic      [4:0]  bankSelect_q,
	output logic      [6:0]  pcHighLatch_q,
	output logic      [15:0] dataPointer0_q,
	output logic      [15:0] dataPointer1_q,
	output logic             zeroFlagWe_q,
	output logic             zeroFlag_q,
	output logic             busy_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	move_ops_pkg::exec_state_t state_q, state_d;
	logic        memReq_d, memWe_d, fileWe_d, zeroFlagWe_d, zeroFlag_d;
	logic [15:0] memAddr_d;
	logic [7:0]  memWdata_d, fileWdata_d, workingReg_d;
	logic [6:0]  fileWaddr_d, pcHighLatch_d;
	logic [4:0]  bankSelect_d;
	logic [15:0] curPtr, effAddr, sextOfs;
	logic        accept, isIndirect, isOffsetForm, isLoad, stepDown;
	logic        step0, step1, toWindow;

	// ----------------------------------------------------------------
	// Pointers
	// ----------------------------------------------------------------
	data_pointer_reg #(.PTR_W(move_ops_pkg::PTR_W)) u_ptr0 (
		.clk      (clk),
		.resetn   (resetn),
		.stepEn   (step0),
		.stepDown (stepDown),
		.pointer_q(dataPointer0_q)
	);

	data_pointer_reg #(.PTR_W(move_ops_pkg::PTR_W)) u_ptr1 (
		.clk      (clk),
		.resetn   (resetn),
		.stepEn   (step1),
		.stepDown (stepDown),
		.pointer_q(dataPointer1_q)
	);

	// ----------------------------------------------------------------
	// Decode and address computation
	// ----------------------------------------------------------------
	// A new operation is refused while a read is outstanding.
	assign accept       = opValid && (state_q == move_ops_pkg::ST_IDLE);
	assign isOffsetForm = (opCode == move_ops_pkg::OP_INDIRECT_LOADK) ||
	                      (opCode == move_ops_pkg::OP_INDIRECT_STOREK);
	assign isIndirect   = isOffsetForm ||
	                      (opCode == move_ops_pkg::OP_INDIRECT_LOAD) ||
	                      (opCode == move_ops_pkg::OP_INDIRECT_STORE);
	assign isLoad       = (opCode == move_ops_pkg::OP_INDIRECT_LOAD) ||
	                      (opCode == move_ops_pkg::OP_INDIRECT_LOADK);
	assign curPtr       = ptrSel ? dataPointer1_q : dataPointer0_q;
	assign sextOfs      = {{(move_ops_pkg::PTR_W - move_ops_pkg::OFS_W)
	                        {offset[move_ops_pkg::OFS_W-1]}}, offset};
	assign stepDown     = pointerUpdateMode[0];
	// Window hits pick the pointer from the low file address bit.
	assign toWindow     = (fileAddr == move_ops_pkg::WINDOW0_ADDR) ||
	                      (fileAddr == move_ops_pkg::WINDOW1_ADDR);

	// Effective address for each mode, wrapping at the 16-bit bound.
	always_comb begin
		case (pointerUpdateMode)
			move_ops_pkg::MODE_PRE_INC:
				effAddr = 16'(curPtr + move_ops_pkg::PTR_ONE);
			move_ops_pkg::MODE_PRE_DEC:
				effAddr = 16'(curPtr - move_ops_pkg::PTR_ONE);
			default:
				effAddr = curPtr;
		endcase
		if (isOffsetForm) begin
			effAddr = 16'(curPtr + sextOfs);
		end
	end

	// The offset form never moves its pointer.
	assign step0 = accept && isIndirect && !isOffsetForm && !ptrSel;
	assign step1 = accept && isIndirect && !isOffsetForm && ptrSel;

	// ----------------------------------------------------------------
	// Execution next state
	// ----------------------------------------------------------------
	// Every path sets all pulses low first so strobes last one cycle.
	always_comb begin
		state_d       = state_q;
		memReq_d      = 1'b0;
		memWe_d       = 1'b0;
		memAddr_d     = memAddr_q;
		memWdata_d    = memWdata_q;
		fileWe_d      = 1'b0;
		fileWaddr_d   = fileWaddr_q;
		fileWdata_d   = fileWdata_q;
		workingReg_d  = workingReg_q;
		bankSelect_d  = bankSelect_q;
		pcHighLatch_d = pcHighLatch_q;
		zeroFlagWe_d  = 1'b0;
		zeroFlag_d    = zeroFlag_q;
		case (state_q)
			move_ops_pkg::ST_IDLE: begin
				if (accept && isIndirect) begin
					memReq_d   = 1'b1;
					memWe_d    = !isLoad;
					memAddr_d  = effAddr;
					memWdata_d = workingReg_q;
					if (isLoad) begin
						state_d = move_ops_pkg::ST_WAIT;
					end
				end else if (accept) begin
					case (opCode)
						move_ops_pkg::OP_LOAD_BANK:
							bankSelect_d =
								literal[move_ops_pkg::BANK_W-1:0];
						move_ops_pkg::OP_LOAD_PC_LATCH:
							pcHighLatch_d =
								literal[move_ops_pkg::LATCH_W-1:0];
						move_ops_pkg::OP_LOAD_LITERAL:
							workingReg_d = literal;
						move_ops_pkg::OP_STORE_WORKING: begin
							if (toWindow) begin
								// A window write lands at the pointer's target.
								memReq_d   = 1'b1;
								memWe_d    = 1'b1;
								memAddr_d  = fileAddr[0] ? dataPointer1_q :
								             dataPointer0_q;
								memWdata_d = workingReg_q;
							end else begin
								fileWe_d    = 1'b1;
								fileWaddr_d = fileAddr;
								fileWdata_d = workingReg_q;
							end
						end
						default: begin
						end
					endcase
				end
			end
			move_ops_pkg::ST_WAIT: begin
				if (memRdValid) begin
					workingReg_d = memRdata;
					zeroFlagWe_d = 1'b1;
					zeroFlag_d   = (memRdata == move_ops_pkg::DATA_RESET);
					state_d      = move_ops_pkg::ST_IDLE;
				end
			end
			default: state_d = move_ops_pkg::ST_IDLE;
		endcase
	end

	// Register.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q       <= move_ops_pkg::ST_IDLE;
			memReq_q      <= 1'b0;
			memWe_q       <= 1'b0;
			memAddr_q     <= move_ops_pkg::PTR_RESET;
			memWdata_q    <= move_ops_pkg::DATA_RESET;
			fileWe_q      <= 1'b0;
			fileWaddr_q   <= move_ops_pkg::WINDOW0_ADDR;
			fileWdata_q   <= move_ops_pkg::DATA_RESET;
			workingReg_q  <= move_ops_pkg::DATA_RESET;
			bankSelect_q  <= move_ops_pkg::BANK_RESET;
			pcHighLatch_q <= move_ops_pkg::LATCH_RESET;
			zeroFlagWe_q  <= 1'b0;
			zeroFlag_q    <= 1'b0;
			busy_q        <= 1'b0;
		end else begin
			state_q       <= state_d;
			memReq_q      <= memReq_d;
			memWe_q       <= memWe_d;
			memAddr_q     <= memAddr_d;
			memWdata_q    <= memWdata_d;
			fileWe_q      <= fileWe_d;
			fileWaddr_q   <= fileWaddr_d;
			fileWdata_q   <= fileWdata_d;
			workingReg_q  <= workingReg_d;
			bankSelect_q  <= bankSelect_d;
			pcHighLatch_q <= pcHighLatch_d;
			zeroFlagWe_q  <= zeroFlagWe_d;
			zeroFlag_q    <= zeroFlag_d;
			busy_q        <= (state_d == move_ops_pkg::ST_WAIT);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_incIssue;
		accept && isIndirect && !isOffsetForm && !ptrSel &&
		(pointerUpdateMode == move_ops_pkg::MODE_PRE_INC);
	endsequence

	property p_preInc;
		s_incIssue |=> (memAddr_q == dataPointer0_q) && memReq_q;
	endproperty
	a_preInc: assert property (p_preInc)
		else $error("pre-increment address mismatch");

	property p_postDec;
		accept && isIndirect && !isOffsetForm && ptrSel &&
		(pointerUpdateMode == move_ops_pkg::MODE_POST_DEC) |=>
		(memAddr_q == 16'(dataPointer1_q + move_ops_pkg::PTR_ONE));
	endproperty
	a_postDec: assert property (p_postDec)
		else $error("post-decrement address mismatch");

	property p_wrap;
		step0 && !stepDown && (dataPointer0_q == 16'hFFFF) |=>
		(dataPointer0_q == move_ops_pkg::PTR_RESET);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("pointer did not wrap to zero");

	property p_ofsKeep;
		accept && isOffsetForm |=> $stable(dataPointer0_q) &&
		$stable(dataPointer1_q) && memReq_q;
	endproperty
	a_ofsKeep: assert property (p_ofsKeep)
		else $error("offset form moved a pointer");

	property p_loadBank;
		accept && (opCode == move_ops_pkg::OP_LOAD_BANK) |=>
		(bankSelect_q == $past(literal[4:0])) && !zeroFlagWe_q;
	endproperty
	a_loadBank: assert property (p_loadBank)
		else $error("bank select not loaded");

	property p_loadLatch;
		accept && (opCode == move_ops_pkg::OP_LOAD_PC_LATCH) |=>
		(pcHighLatch_q == $past(literal[6:0]));
	endproperty
	a_loadLatch: assert property (p_loadLatch)
		else $error("pc latch not loaded");

	property p_loadLit;
		accept && (opCode == move_ops_pkg::OP_LOAD_LITERAL) |=>
		(workingReg_q == $past(literal)) && !busy_q;
	endproperty
	a_loadLit: assert property (p_loadLit)
		else $error("working register not loaded");

	property p_store;
		accept && (opCode == move_ops_pkg::OP_STORE_WORKING) && !toWindow |=>
		fileWe_q && (fileWdata_q == workingReg_q) && $stable(workingReg_q);
	endproperty
	a_store: assert property (p_store)
		else $error("store did not write file register");

	property p_window;
		accept && (opCode == move_ops_pkg::OP_STORE_WORKING) && toWindow |=>
		!fileWe_q && memReq_q && memWe_q;
	endproperty
	a_window: assert property (p_window)
		else $error("window store touched file register");

	// Read data may come back after any latency, so key on its arrival.
	sequence s_readReturn;
		busy_q && memRdValid;
	endsequence
	property p_readDone;
		s_readReturn |=>
		(workingReg_q == $past(memRdata)) && zeroFlagWe_q && !busy_q;
	endproperty
	a_readDone: assert property (p_readDone)
		else $error("indirect load did not update working register");

endmodule // literal_and_indirect_moves

// ---- pkg/move_ops_pkg.sv ----
// Constants shared by the literal and indirect move execution logic.
package move_ops_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PTR_W    = 16;
	localparam int DATA_W   = 8;
	localparam int BANK_W   = 5;
	localparam int LATCH_W  = 7;
	localparam int FILE_W   = 7;
	localparam int OFS_W    = 6;
	localparam int OP_W     = 4;

	// ----------------------------------------------------------------
	// Operation codes from the decode stage
	// ----------------------------------------------------------------
	localparam logic [OP_W-1:0] OP_NONE            = 4'h0;
	localparam logic [OP_W-1:0] OP_INDIRECT_LOAD   = 4'h1;
	localparam logic [OP_W-1:0] OP_INDIRECT_STORE  = 4'h2;
	localparam logic [OP_W-1:0] OP_INDIRECT_LOADK  = 4'h3;
	localparam logic [OP_W-1:0] OP_INDIRECT_STOREK = 4'h4;
	localparam logic [OP_W-1:0] OP_LOAD_BANK       = 4'h5;
	localparam logic [OP_W-1:0] OP_LOAD_PC_LATCH   = 4'h6;
	localparam logic [OP_W-1:0] OP_LOAD_LITERAL    = 4'h7;
	localparam logic [OP_W-1:0] OP_STORE_WORKING   = 4'h8;

	// ----------------------------------------------------------------
	// Pointer update modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_PRE_INC  = 2'h0;
	localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
	localparam logic [1:0] MODE_POST_INC = 2'h2;
	localparam logic [1:0] MODE_POST_DEC = 2'h3;

	// ----------------------------------------------------------------
	// File addresses of the indirect windows and reset values
	// ----------------------------------------------------------------
	localparam logic [FILE_W-1:0] WINDOW0_ADDR = 7'h00;
	localparam logic [FILE_W-1:0] WINDOW1_ADDR = 7'h01;
	localparam logic [PTR_W-1:0]  PTR_RESET    = 16'h0000;
	localparam logic [PTR_W-1:0]  PTR_ONE      = 16'h0001;
	localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RESET   = 5'h00;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h00;

	// Issue and read-wait states, one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} exec_state_t;

endpackage

// ---- test/tb_top.sv ----
// Self-checking bench for the literal and indirect move execution block.
`timescale 1ns/10ps
module tb_top;
	// ------------------------------------------------------------
	// Stimulus, outputs and bench bookkeeping
	// ------------------------------------------------------------
	logic        clk, resetn, opValid, ptrSel, memRdValid;
	logic [3:0]  opCode;
	logic [1:0]  pointerUpdateMode;
	logic [5:0]  offset;
	logic [7:0]  literal, memRdata, memWdata_q, fileWdata_q, workingReg_q;
	logic [6:0]  fileAddr, fileWaddr_q, pcHighLatch_q;
	logic [15:0] memAddr_q, dataPointer0_q, dataPointer1_q;
	logic [4:0]  bankSelect_q;
	logic        memReq_q, memWe_q, fileWe_q, zeroFlagWe_q, zeroFlag_q, busy_q;
	int          errCount, nTests;
	logic [24:0] memQ[$];
	logic [14:0] fileQ[$];
	logic [8:0]  loadQ[$];
	logic [24:0] eMem;
	logic [14:0] eFile;
	logic [8:0]  eLoad;
	logic [15:0] ptr[2];
	logic [7:0]  w, v;

	literal_and_indirect_moves i_literal_and_indirect_moves (
		.clk(clk), .resetn(resetn), .opValid(opValid), .opCode(opCode),
		.ptrSel(ptrSel), .pointerUpdateMode(pointerUpdateMode),
		.offset(offset), .literal(literal), .fileAddr(fileAddr),
		.memRdValid(memRdValid), .memRdata(memRdata), .memReq_q(memReq_q),
		.memWe_q(memWe_q), .memAddr_q(memAddr_q), .memWdata_q(memWdata_q),
		.fileWe_q(fileWe_q), .fileWaddr_q(fileWaddr_q),
		.fileWdata_q(fileWdata_q), .workingReg_q(workingReg_q),
		.bankSelect_q(bankSelect_q), .pcHighLatch_q(pcHighLatch_q),
		.dataPointer0_q(dataPointer0_q), .dataPointer1_q(dataPointer1_q),
		.zeroFlagWe_q(zeroFlagWe_q), .zeroFlag_q(zeroFlag_q), .busy_q(busy_q)
	);

	// Free-running core clock, 5 ns period.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, exp, input string what);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %0t %s: saw %0h, wanted %0h", $time, what, seen, exp);
		end
	endtask

	task automatic printVerdict();
		$display("Comparisons %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Holds one operation over one edge; opValid stays up for back to back.
	task automatic issue(input logic [3:0] op, input logic s,
		input logic [1:0] m, input logic [5:0] o, input logic [7:0] lit,
		input logic [6:0] fa);
		opValid = 1'b1;
		opCode = op;
		ptrSel = s;
		pointerUpdateMode = m;
		offset = o;
		literal = lit;
		fileAddr = fa;
		@(posedge clk);
		#1;
	endtask

	// Mode bit 0 picks decrement, bit 1 picks post; offset form keeps it.
	task automatic expAddr(input logic s, input logic [1:0] m,
		input logic k, input logic [5:0] o, output logic [15:0] a);
		logic [15:0] nxt;
		nxt = m[0] ? ptr[s] - 16'h0001 : ptr[s] + 16'h0001;
		a = k ? ptr[s] + {{10{o[5]}}, o} : (m[1] ? ptr[s] : nxt);
		if (!k) ptr[s] = nxt;
	endtask

	task automatic indLoad(input logic s, input logic [1:0] m,
		input logic k, input logic [5:0] o, input logic [7:0] d);
		logic [15:0] a;
		int i;
		expAddr(s, m, k, o, a);
		memQ.push_back({1'b0, a, 8'h00});
		loadQ.push_back({d == 8'h00, d});
		issue(k ? move_ops_pkg::OP_INDIRECT_LOADK
			: move_ops_pkg::OP_INDIRECT_LOAD, s, m, o, ~d, 7'h00);
		check(busy_q, 1'b1, "busy after load");
		// A literal load held up while waiting must be ignored.
		opCode = move_ops_pkg::OP_LOAD_LITERAL;
		repeat ($urandom_range(3, 1)) @(posedge clk);
		#1;
		check(workingReg_q, w, "refused while busy");
		opValid = 1'b0;
		memRdValid = 1'b1;
		memRdata = d;
		@(posedge clk);
		#1;
		memRdValid = 1'b0;
		memRdata = ~d;
		for (i = 0; i < 8 && busy_q !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 8) begin
			check(busy_q, 1'b0, "load never completed");
			printVerdict();
		end
		w = d;
		check(workingReg_q, w, "loaded byte");
		check(s ? dataPointer1_q : dataPointer0_q, ptr[s], "ptr");
	endtask

	task automatic indStore(input logic s, input logic [1:0] m,
		input logic k, input logic [5:0] o);
		logic [15:0] a;
		expAddr(s, m, k, o, a);
		memQ.push_back({1'b1, a, w});
		issue(k ? move_ops_pkg::OP_INDIRECT_STOREK
			: move_ops_pkg::OP_INDIRECT_STORE, s, m, o, ~w, 7'h00);
		check(s ? dataPointer1_q : dataPointer0_q, ptr[s], "ptr");
	endtask

	// Watches the strobes; any strobe with no note pending is a fault.
	always @(posedge clk) begin
		#2;
		if (resetn === 1'b1 && memReq_q !== 1'b0) begin
			eMem = memQ.size() ? memQ.pop_front() : 25'h1FFFFFF;
			check(memWe_q, eMem[24], "mem direction");
			check(memAddr_q, eMem[23:8], "mem address");
			if (eMem[24]) check(memWdata_q, eMem[7:0], "mem data");
		end
		if (resetn === 1'b1 && fileWe_q !== 1'b0) begin
			eFile = fileQ.size() ? fileQ.pop_front() : 15'h7FFF;
			check({fileWaddr_q, fileWdata_q}, eFile, "file write");
		end
		if (resetn === 1'b1 && zeroFlagWe_q !== 1'b0) begin
			eLoad = loadQ.size() ? loadQ.pop_front() : 9'h1FF;
			check({zeroFlag_q, workingReg_q}, eLoad, "zero flag");
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h7B56));
		{resetn, opValid, ptrSel, memRdValid, pointerUpdateMode} = 6'h00;
		{opCode, offset, literal, memRdata, fileAddr} = 33'h000000000;
		ptr[0] = 16'h0000;
		ptr[1] = 16'h0000;
		w = 8'h00;
		repeat (12) @(posedge clk);
		#1;
		resetn = 1'b1;
		check({workingReg_q, bankSelect_q, pcHighLatch_q}, 0, "reset");
		check({dataPointer0_q, dataPointer1_q, busy_q}, 0, "reset");
		$display("Test reset values done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom());
			issue(move_ops_pkg::OP_LOAD_LITERAL, 1'b0, 2'h0, 6'h00, v, 7'h00);
			w = v;
			check(workingReg_q, v, "literal");
			issue(move_ops_pkg::OP_LOAD_BANK, 1'b0, 2'h0, 6'h00, ~v, 7'h00);
			check(bankSelect_q, 5'(~v), "bank");
			issue(move_ops_pkg::OP_LOAD_PC_LATCH, 1'b0, 2'h0, 6'h00, v, 7'h00);
			check(pcHighLatch_q, v[6:0], "latch");
			check(workingReg_q, w, "W kept");
		end
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h7F : 8'($urandom_range(127, 2));
			fileQ.push_back({v[6:0], w});
			issue(move_ops_pkg::OP_STORE_WORKING, 1'b0, 2'h0, 6'h00, ~w, v[6:0]);
			check(workingReg_q, w, "W after store");
		end
		$display("Test literal loads and stores done");
		indLoad(1'b0, move_ops_pkg::MODE_PRE_DEC, 1'b0, 6'h00, 8'h3C);
		indLoad(1'b0, move_ops_pkg::MODE_POST_INC, 1'b0, 6'h00, 8'h00);
		indLoad(1'b1, move_ops_pkg::MODE_PRE_INC, 1'b0, 6'h00, 8'hC3);
		indLoad(1'b1, move_ops_pkg::MODE_POST_DEC, 1'b0, 6'h00, 8'h81);
		for (int i = 0; i < 4; i++)
			indLoad(1'($urandom()), 2'($urandom()), 1'b0, 6'h00, 8'($urandom()));
		indLoad(1'b1, 2'h2, 1'b1, 6'h20, 8'h55);
		indLoad(1'b0, 2'h1, 1'b1, 6'h1F, 8'hAA);
		$display("Test indirect loads done");
		for (int m = 0; m < 4; m++)
			indStore(1'(m), 2'(m), 1'b0, 6'h00);
		indStore(1'b0, 2'h0, 1'b1, 6'h3F);
		for (int s = 0; s < 2; s++) begin
			memQ.push_back({1'b1, ptr[s], w});
			issue(move_ops_pkg::OP_STORE_WORKING, 1'b0, 2'h0, 6'h00, ~w, 7'(s));
		end
		opValid = 1'b0;
		$display("Test indirect stores done");
		repeat (4) @(posedge clk);
		#1;
		check(memQ.size() + fileQ.size() + loadQ.size(), 0, "pending");
		printVerdict();
	end
endmodule // tb_top
